// [hdl/fca_cmd_decode.sv]
// command decoder: turns opcode writes into whole commands
`timescale 1ns/1ps
`default_nettype none
module fca_cmd_decode
    import fca_pkg::*;
(
    // clock and reset
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic clkEn,
    // command writes
    input wire logic cmdWr,
    input wire logic [7:0] cmdByte,
    input wire logic abort,
    // decoded command, one-cycle pulse
    output logic cmdValid,
    output fca_cmd_t cmdKind
);
    typedef enum logic [1:0] {
        FCA_D_OP = 2'b00,
        FCA_D_COUNT = 2'b01,
        FCA_D_DATA = 2'b10,
        FCA_D_FINAL = 2'b11
    } fca_dstate_t;

    typedef struct packed {
        fca_dstate_t st;
        fca_cmd_t pend;
        logic [7:0] left;
        logic valid;
        fca_cmd_t kind;
    } fca_dec_t;

    fca_dec_t s_q, s_d;

    always_comb begin
        s_d = s_q;
        s_d.valid = 1'b0;
        s_d.kind = FCA_C_NONE;
        if (abort) begin
            s_d.st = FCA_D_OP;
        end else if (cmdWr) begin
            unique case (s_q.st)
                FCA_D_OP: begin
                    unique case (cmdByte)
                        FCA_OP_PROG: begin
                            s_d.pend = FCA_C_PROG;
                            s_d.st = FCA_D_COUNT;
                        end
                        FCA_OP_CONFIG: begin
                            s_d.pend = FCA_C_CONFIG;
                            s_d.st = FCA_D_COUNT;
                        end
                        FCA_OP_ERASE: begin
                            s_d.pend = FCA_C_ERASE;
                            s_d.st = FCA_D_FINAL;
                        end
                        FCA_OP_MERASE: begin
                            s_d.pend = FCA_C_MERASE;
                            s_d.st = FCA_D_FINAL;
                        end
                        FCA_OP_BLANK: begin
                            s_d.pend = FCA_C_BLANK;
                            s_d.st = FCA_D_FINAL;
                        end
                        FCA_OP_SUSPEND: begin
                            s_d.valid = 1'b1;
                            s_d.kind = FCA_C_SUSPEND;
                        end
                        FCA_OP_RESUME: begin
                            s_d.valid = 1'b1;
                            s_d.kind = FCA_C_RESUME;
                        end
                        FCA_OP_CLEAR: begin
                            s_d.valid = 1'b1;
                            s_d.kind = FCA_C_CLEAR;
                        end
                        FCA_OP_STOP: begin
                            s_d.valid = 1'b1;
                            s_d.kind = FCA_C_STOP;
                        end
                        default: begin
                            s_d.valid = 1'b1;
                            s_d.kind = FCA_C_BADSEQ;
                        end
                    endcase
                end
                FCA_D_COUNT: begin
                    s_d.left = cmdByte;
                    s_d.st = (cmdByte == 8'h00) ? FCA_D_FINAL : FCA_D_DATA;
                end
                FCA_D_DATA: begin
                    s_d.left = s_q.left - 8'h01;
                    if (s_q.left == 8'h01) begin
                        s_d.st = FCA_D_FINAL;
                    end
                end
                FCA_D_FINAL: begin
                    s_d.valid = 1'b1;
                    s_d.kind = (cmdByte == FCA_OP_FINAL) ? s_q.pend : FCA_C_BADSEQ;
                    s_d.st = FCA_D_OP;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            s_q <= '{st: FCA_D_OP, pend: FCA_C_NONE, left: 8'h00, valid: 1'b0,
                     kind: FCA_C_NONE};
        end else if (clkEn) begin
            s_q <= s_d;
        end
    end

    assign cmdValid = s_q.valid;
    assign cmdKind = s_q.kind;
endmodule // fca_cmd_decode
`default_nettype wire

// [hdl/fca_op_timer.sv]
// operation timer: counts down the length of a flash operation
`timescale 1ns/1ps
`default_nettype none
module fca_op_timer
    import fca_pkg::*;
#(
    parameter int CNT_W = FCA_CNT_W
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic clkEn,
    // control
    input wire logic load,
    input wire logic [CNT_W-1:0] loadVal,
    input wire logic hold,
    // status
    output logic done
);
    typedef struct packed {
        logic [CNT_W-1:0] cnt;
        logic run;
        logic done;
    } fca_tmr_t;

    fca_tmr_t s_q, s_d;

    always_comb begin
        s_d = s_q;
        s_d.done = 1'b0;
        if (load) begin
            s_d.cnt = loadVal;
            s_d.run = 1'b1;
        end else if (s_q.run && !hold) begin
            if (s_q.cnt <= CNT_W'(1)) begin
                s_d.run = 1'b0;
                s_d.done = 1'b1;
            end else begin
                s_d.cnt = s_q.cnt - CNT_W'(1);
            end
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            s_q <= '{cnt: '0, run: 1'b0, done: 1'b0};
        end else if (clkEn) begin
            s_q <= s_d;
        end
    end

    assign done = s_q.done;
endmodule // fca_op_timer
`default_nettype wire

// [hdl/fca_pkg.sv]
// package: constants, modes, states and commands of the flash command acceptance block
package fca_pkg;
    // ------------------------------------------------------------
    // register map (word offsets are byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] FCA_ADDR_MODE = 8'h00;
    localparam logic [7:0] FCA_ADDR_CMD = 8'h04;
    localparam logic [7:0] FCA_ADDR_STATUS = 8'h08;
    localparam logic [7:0] FCA_ADDR_ACCESS = 8'h0C;
    localparam logic [7:0] FCA_ADDR_CLKNOTE = 8'h10;
    localparam logic [7:0] FCA_ADDR_TARGET = 8'h14;
    // ------------------------------------------------------------
    // mode select values and fields
    // ------------------------------------------------------------
    localparam logic [15:0] FCA_MODE_READ = 16'h0000;
    localparam logic [15:0] FCA_MODE_CODE = 16'h0001;
    localparam logic [15:0] FCA_MODE_DATA = 16'h0080;
    localparam int FCA_BIT_CODE_ENTRY = 0;
    localparam int FCA_BIT_DATA_ENTRY = 7;
    // ------------------------------------------------------------
    // opcode bytes
    // ------------------------------------------------------------
    localparam logic [7:0] FCA_OP_PROG = 8'hE8;
    localparam logic [7:0] FCA_OP_ERASE = 8'h20;
    localparam logic [7:0] FCA_OP_MERASE = 8'h21;
    localparam logic [7:0] FCA_OP_SUSPEND = 8'hB0;
    localparam logic [7:0] FCA_OP_RESUME = 8'hD0;
    localparam logic [7:0] FCA_OP_CLEAR = 8'h50;
    localparam logic [7:0] FCA_OP_STOP = 8'hB3;
    localparam logic [7:0] FCA_OP_BLANK = 8'h71;
    localparam logic [7:0] FCA_OP_CONFIG = 8'h40;
    localparam logic [7:0] FCA_OP_FINAL = 8'hD0;
    // ------------------------------------------------------------
    // status word bit positions
    // ------------------------------------------------------------
    localparam int FCA_ST_ILGL = 0;
    localparam int FCA_ST_ILGCOM = 1;
    localparam int FCA_ST_FESET = 2;
    localparam int FCA_ST_SEC = 3;
    localparam int FCA_ST_OT = 4;
    localparam int FCA_ST_ERS = 5;
    localparam int FCA_ST_PRG = 6;
    localparam int FCA_ST_WE = 7;
    localparam int FCA_ST_PROGRAM_SUSPENDED_FLAG = 8;
    localparam int FCA_ST_ERASE_SUSPENDED_FLAG = 9;
    localparam int FCA_ST_WRITE_BUFFER_FULL_FLAG = 10;
    localparam int FCA_ST_SUSPEND_READY_FLAG = 11;
    localparam int FCA_ST_RDY = 15;
    localparam int FCA_ERR_W = 8;
    // ------------------------------------------------------------
    // timing (cycles at 100 MHz)
    // ------------------------------------------------------------
    localparam int FCA_CLK_MHZ = 100;
    localparam int FCA_OP_TIME_NS = 1000;
    localparam int FCA_SUS_TIME_NS = 200;
    localparam int FCA_OP_CYCLES = (FCA_OP_TIME_NS * FCA_CLK_MHZ + 999) / 1000;
    localparam int FCA_SUS_CYCLES = (FCA_SUS_TIME_NS * FCA_CLK_MHZ + 999) / 1000;
    localparam int FCA_SUSPEND_READY_FLAG_DELAY = 4;
    localparam int FCA_CNT_W = 16;
    localparam logic [15:0] FCA_TARGET_RST = 16'h0000;
    localparam logic [15:0] FCA_CLKNOTE_RST = 16'h0064;

    // ------------------------------------------------------------
    // sequencer states
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        FCA_IDLE = 4'b0000,
        FCA_PE_BUSY = 4'b0001,
        FCA_CFG_BUSY = 4'b0010,
        FCA_SUSPENDING = 4'b0011,
        FCA_BLANK_BUSY = 4'b0100,
        FCA_PRG_SUSP = 4'b0101,
        FCA_ERS_SUSP = 4'b0110,
        FCA_PRG_IN_ES = 4'b0111,
        FCA_LOCKED = 4'b1000,
        FCA_STOPPING = 4'b1001
    } fca_state_t;

    // decoded command kinds
    typedef enum logic [3:0] {
        FCA_C_NONE = 4'b0000,
        FCA_C_PROG = 4'b0001,
        FCA_C_ERASE = 4'b0010,
        FCA_C_MERASE = 4'b0011,
        FCA_C_SUSPEND = 4'b0100,
        FCA_C_RESUME = 4'b0101,
        FCA_C_CLEAR = 4'b0110,
        FCA_C_STOP = 4'b0111,
        FCA_C_BLANK = 4'b1000,
        FCA_C_CONFIG = 4'b1001,
        FCA_C_BADSEQ = 4'b1010
    } fca_cmd_t;
endpackage

// [hdl/fca_sequencer.sv]
// flash command acceptance: modes, sequencer state, flags and register port
`timescale 1ns/1ps
`default_nettype none
module fca_sequencer
    import fca_pkg::*;
#(
    parameter int OP_CYCLES = FCA_OP_CYCLES,
    parameter int SUS_CYCLES = FCA_SUS_CYCLES
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic clkEn,
    // register port
    input wire logic [7:0] regAddr,
    input wire logic [15:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    output logic [15:0] regRdata,
    // array result inputs (from the flash macro, asynchronous)
    input wire logic arrayProgFail,
    input wire logic arrayEraseFail,
    input wire logic writeProtect,
    input wire logic securityBlock,
    // status outputs
    output logic sequencerReadyFlag,
    output logic commandLockFlag,
    output logic [15:0] sequencerModeSelect
);
    // ------------------------------------------------------------
    // state record
    // ------------------------------------------------------------
    typedef struct packed {
        fca_state_t st;
        logic [15:0] mode;
        logic [FCA_ERR_W-1:0] err;
        logic program_suspended_flag;
        logic erase_suspended_flag;
        logic suspend_ready_flag;
        logic rdy;
        logic write_buffer_full_flag;
        logic isProg;
        logic lock;
        logic [1:0] susWait;
        logic [15:0] target;
        logic [15:0] suspBlock;
        logic [15:0] clkNote;
        logic [15:0] rdata;
        logic [1:0] syncProg;
        logic [1:0] syncErs;
        logic [1:0] syncWp;
        logic [1:0] syncSec;
    } fca_seq_t;

    fca_seq_t s_q, s_d;

    logic cmdValid;
    fca_cmd_t cmdKind;
    logic tmrLoad;
    logic [FCA_CNT_W-1:0] tmrVal;
    logic tmrDone;
    logic cmdWr;
    logic lockNow;

    function automatic logic isCodeMode(input logic [15:0] m);
        return m == FCA_MODE_CODE;
    endfunction

    function automatic logic isDataMode(input logic [15:0] m);
        return m == FCA_MODE_DATA;
    endfunction

    // ------------------------------------------------------------
    // submodules
    // ------------------------------------------------------------
    // writes in read mode never reach the decoder
    assign cmdWr = regWr && (regAddr == FCA_ADDR_CMD) && (s_q.mode != FCA_MODE_READ);

    fca_cmd_decode u_dec (
        .core_clk(core_clk),
        .nrst(nrst),
        .clkEn(clkEn),
        .cmdWr(cmdWr),
        .cmdByte(regWdata[7:0]),
        .abort(s_q.mode == FCA_MODE_READ),
        .cmdValid(cmdValid),
        .cmdKind(cmdKind)
    );

    fca_op_timer #(.CNT_W(FCA_CNT_W)) u_tmr (
        .core_clk(core_clk),
        .nrst(nrst),
        .clkEn(clkEn),
        .load(tmrLoad),
        .loadVal(tmrVal),
        .hold(1'b0),
        .done(tmrDone)
    );

    assign lockNow = |s_q.err;

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        s_d = s_q;
        tmrLoad = 1'b0;
        tmrVal = FCA_CNT_W'(OP_CYCLES);
        s_d.syncProg = {s_q.syncProg[0], arrayProgFail};
        s_d.syncErs = {s_q.syncErs[0], arrayEraseFail};
        s_d.syncWp = {s_q.syncWp[0], writeProtect};
        s_d.syncSec = {s_q.syncSec[0], securityBlock};

        // register writes
        if (regWr) begin
            unique case (regAddr)
                FCA_ADDR_MODE: begin
                    // only a single entry bit or zero is a legal mode
                    if (regWdata == FCA_MODE_READ || regWdata == FCA_MODE_CODE
                            || regWdata == FCA_MODE_DATA) begin
                        s_d.mode = regWdata;
                    end
                end
                FCA_ADDR_TARGET: s_d.target = regWdata;
                FCA_ADDR_CLKNOTE: s_d.clkNote = regWdata;
                default: ;
            endcase
        end

        // completion of running work
        if (tmrDone) begin
            unique case (s_q.st)
                FCA_PE_BUSY, FCA_CFG_BUSY, FCA_BLANK_BUSY, FCA_STOPPING: begin
                    s_d.st = FCA_IDLE;
                    s_d.rdy = 1'b1;
                    s_d.suspend_ready_flag = 1'b0;
                    s_d.write_buffer_full_flag = 1'b0;
                end
                FCA_PRG_IN_ES: begin
                    s_d.st = FCA_ERS_SUSP;
                    s_d.rdy = 1'b1;
                end
                FCA_SUSPENDING: begin
                    s_d.st = s_q.program_suspended_flag ? FCA_PRG_SUSP : FCA_ERS_SUSP;
                    s_d.rdy = 1'b1;
                end
                default: ;
            endcase
        end

        // suspend becomes possible a little after start
        if (s_q.st == FCA_PE_BUSY && !s_q.suspend_ready_flag) begin
            if (s_q.susWait == 2'(FCA_SUSPEND_READY_FLAG_DELAY - 1)) begin
                s_d.suspend_ready_flag = 1'b1;
            end else begin
                s_d.susWait = s_q.susWait + 2'h1;
            end
        end

        // array errors sampled after the synchronisers
        if (s_q.st == FCA_PE_BUSY || s_q.st == FCA_PRG_IN_ES) begin
            if (s_q.syncProg[1]) s_d.err[FCA_ST_PRG] = 1'b1;
            if (s_q.syncErs[1]) s_d.err[FCA_ST_ERS] = 1'b1;
            if (s_q.syncWp[1]) s_d.err[FCA_ST_WE] = 1'b1;
            if (s_q.syncSec[1]) s_d.err[FCA_ST_SEC] = 1'b1;
        end

        // command acceptance
        if (cmdValid) begin
            unique case (cmdKind)
                FCA_C_STOP: begin
                    // accepted in every state; clears all status
                    s_d.st = FCA_STOPPING;
                    s_d.err = '0;
                    s_d.program_suspended_flag = 1'b0;
                    s_d.erase_suspended_flag = 1'b0;
                    s_d.suspend_ready_flag = 1'b0;
                    s_d.write_buffer_full_flag = 1'b0;
                    s_d.rdy = 1'b0;
                    tmrLoad = 1'b1;
                    tmrVal = FCA_CNT_W'(SUS_CYCLES);
                end
                FCA_C_CLEAR: begin
                    if (s_q.rdy && (s_q.st == FCA_IDLE || s_q.st == FCA_PRG_SUSP
                            || s_q.st == FCA_ERS_SUSP || s_q.st == FCA_LOCKED)) begin
                        s_d.err = '0;
                        if (s_q.st == FCA_LOCKED) begin
                            s_d.st = s_q.program_suspended_flag ? FCA_PRG_SUSP :
                                     s_q.erase_suspended_flag ? FCA_ERS_SUSP : FCA_IDLE;
                        end
                    end else begin
                        s_d.err[FCA_ST_ILGL] = 1'b1;
                    end
                end
                FCA_C_SUSPEND: begin
                    if (s_q.st == FCA_PE_BUSY && s_q.suspend_ready_flag) begin
                        s_d.st = FCA_SUSPENDING;
                        s_d.suspend_ready_flag = 1'b0;
                        tmrLoad = 1'b1;
                        tmrVal = FCA_CNT_W'(SUS_CYCLES);
                        s_d.program_suspended_flag = s_q.isProg;
                        s_d.erase_suspended_flag = !s_q.isProg;
                    end else if (s_q.st == FCA_IDLE
                            || (s_q.st == FCA_LOCKED && s_q.rdy)) begin
                        s_d.st = s_q.st;
                    end else begin
                        s_d.err[FCA_ST_ILGL] = 1'b1;
                    end
                end
                FCA_C_RESUME: begin
                    if (s_q.st == FCA_PRG_SUSP || s_q.st == FCA_ERS_SUSP) begin
                        s_d.st = FCA_PE_BUSY;
                        s_d.isProg = (s_q.st == FCA_PRG_SUSP);
                        s_d.program_suspended_flag = 1'b0;
                        s_d.erase_suspended_flag = 1'b0;
                        s_d.rdy = 1'b0;
                        s_d.susWait = 2'h0;
                        tmrLoad = 1'b1;
                    end else begin
                        s_d.err[FCA_ST_ILGL] = 1'b1;
                    end
                end
                FCA_C_PROG: begin
                    if (s_q.st == FCA_IDLE) begin
                        s_d.st = FCA_PE_BUSY;
                        s_d.isProg = 1'b1;
                        s_d.rdy = 1'b0;
                        s_d.susWait = 2'h0;
                        s_d.suspBlock = s_q.target;
                        tmrLoad = 1'b1;
                    end else if (s_q.st == FCA_ERS_SUSP && s_q.target != s_q.suspBlock) begin
                        s_d.st = FCA_PRG_IN_ES;
                        s_d.rdy = 1'b0;
                        tmrLoad = 1'b1;
                    end else begin
                        s_d.err[FCA_ST_ILGL] = 1'b1;
                    end
                end
                FCA_C_ERASE: begin
                    if (s_q.st == FCA_IDLE) begin
                        s_d.st = FCA_PE_BUSY;
                        s_d.isProg = 1'b0;
                        s_d.rdy = 1'b0;
                        s_d.susWait = 2'h0;
                        s_d.suspBlock = s_q.target;
                        tmrLoad = 1'b1;
                    end else begin
                        s_d.err[FCA_ST_ILGL] = 1'b1;
                    end
                end
                FCA_C_MERASE: begin
                    if (s_q.st == FCA_IDLE && isDataMode(s_q.mode)) begin
                        s_d.st = FCA_PE_BUSY;
                        s_d.isProg = 1'b0;
                        s_d.rdy = 1'b0;
                        s_d.susWait = 2'h0;
                        s_d.suspBlock = s_q.target;
                        tmrLoad = 1'b1;
                    end else begin
                        s_d.err[FCA_ST_ILGL] = 1'b1;
                    end
                end
                FCA_C_BLANK: begin
                    if (isDataMode(s_q.mode) && (s_q.st == FCA_IDLE
                            || s_q.st == FCA_PRG_SUSP || s_q.st == FCA_ERS_SUSP)) begin
                        s_d.st = FCA_BLANK_BUSY;
                        s_d.rdy = 1'b0;
                        tmrLoad = 1'b1;
                    end else begin
                        s_d.err[FCA_ST_ILGL] = 1'b1;
                    end
                end
                FCA_C_CONFIG: begin
                    if (isCodeMode(s_q.mode) && s_q.st == FCA_IDLE) begin
                        s_d.st = FCA_CFG_BUSY;
                        s_d.rdy = 1'b0;
                        tmrLoad = 1'b1;
                    end else begin
                        s_d.err[FCA_ST_ILGL] = 1'b1;
                    end
                end
                FCA_C_BADSEQ: s_d.err[FCA_ST_ILGCOM] = 1'b1;
                default: ;
            endcase
        end

        // any error forces the locked state except while stopping, ready left as is
        if (|s_d.err && s_d.st != FCA_STOPPING) begin
            s_d.st = FCA_LOCKED;
        end
        s_d.lock = |s_d.err;

        // read data appear the cycle after the strobe
        s_d.rdata = 16'h0000;
        if (regRd) begin
            unique case (regAddr)
                FCA_ADDR_MODE: s_d.rdata = s_q.mode;
                FCA_ADDR_STATUS: begin
                    s_d.rdata[FCA_ST_WE:FCA_ST_ILGL] = s_q.err;
                    s_d.rdata[FCA_ST_PROGRAM_SUSPENDED_FLAG] = s_q.program_suspended_flag;
                    s_d.rdata[FCA_ST_ERASE_SUSPENDED_FLAG] = s_q.erase_suspended_flag;
                    s_d.rdata[FCA_ST_WRITE_BUFFER_FULL_FLAG] = s_q.write_buffer_full_flag;
                    s_d.rdata[FCA_ST_SUSPEND_READY_FLAG] = s_q.suspend_ready_flag;
                    s_d.rdata[FCA_ST_RDY] = s_q.rdy;
                end
                FCA_ADDR_ACCESS: s_d.rdata = {15'h0000, lockNow};
                FCA_ADDR_CLKNOTE: s_d.rdata = s_q.clkNote;
                FCA_ADDR_TARGET: s_d.rdata = s_q.target;
                default: s_d.rdata = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            s_q <= '{st: FCA_IDLE, mode: FCA_MODE_READ, rdy: 1'b1, target: FCA_TARGET_RST,
                     clkNote: FCA_CLKNOTE_RST, default: '0};
        end else if (clkEn) begin
            s_q <= s_d;
        end
    end

    assign regRdata = s_q.rdata;
    assign sequencerReadyFlag = s_q.rdy;
    assign commandLockFlag = s_q.lock;
    assign sequencerModeSelect = s_q.mode;
endmodule // fca_sequencer
`default_nettype wire

// [test/fca_checker.sv]
// assertions on the ports of the flash command acceptance sequencer
`timescale 1ns/1ps
`default_nettype none
module fca_checker
    import fca_pkg::*;
(
    // clock and reset
    input wire logic core_clk,
    input wire logic nrst,
    // register port
    input wire logic [7:0] regAddr,
    input wire logic [15:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    input wire logic [15:0] regRdata,
    // status
    input wire logic sequencerReadyFlag,
    input wire logic commandLockFlag,
    input wire logic [15:0] sequencerModeSelect
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!nrst);
    logic cmdW;
    logic rdy;
    logic lk;
    assign cmdW = regWr && regAddr == FCA_ADDR_CMD;
    assign rdy = sequencerReadyFlag;
    assign lk = commandLockFlag;
    a_reset_idle: assert property ($past(!nrst) |-> rdy && !lk && sequencerModeSelect == 16'h0000)
        else $error("sequencer not idle after reset");
    a_mode_write: assert property (regWr && regAddr == FCA_ADDR_MODE |=> sequencerModeSelect == $past(regWdata))
        else $error("mode select not taken");
    a_status_read: assert property (regRd && regAddr == FCA_ADDR_STATUS |=> {regRdata[FCA_ST_RDY], |regRdata[7:0]} == $past({rdy, lk}))
        else $error("status word disagrees with flags");
    a_read_quiet: assert property (sequencerModeSelect == 16'h0000 && rdy && cmdW |=> rdy [*3])
        else $error("command started in read mode");
    a_ready_cause: assert property ($fell(rdy) |-> $past(cmdW) || $past(cmdW, 2))
        else $error("ready fell without a command");
    a_clear_keeps: assert property (cmdW && regWdata[7:0] == FCA_OP_CLEAR && rdy |=> rdy [*3])
        else $error("status clear dropped ready");
    a_clear_unlock: assert property (cmdW && regWdata[7:0] == FCA_OP_CLEAR && rdy && lk |-> ##[1:4] !lk)
        else $error("status clear left lock set");
    a_stop_unlock: assert property (cmdW && regWdata[7:0] == FCA_OP_STOP |-> ##[1:200] rdy && !lk)
        else $error("forced stop did not recover");
endmodule // fca_checker

bind fca_sequencer fca_checker fca_checker_inst (.*);
`default_nettype wire

// [test/tb.sv]
// self-checking bench for the flash command acceptance sequencer
`timescale 1ns/1ps
`default_nettype none
module tb;
    import fca_pkg::*;
    logic core_clk = 1'h0, nrst = 1'h0, clkEn = 1'h1, regWr = 1'h0, regRd = 1'h0;
    logic arrayProgFail = 1'h0, arrayEraseFail = 1'h0, writeProtect = 1'h0, securityBlock = 1'h0;
    logic [7:0] regAddr = 8'h00;
    logic [15:0] regWdata = 16'h0000, regRdata, sequencerModeSelect, st;
    logic sequencerReadyFlag, commandLockFlag;
    wire logic [1:0] flags = {sequencerReadyFlag, commandLockFlag};
    int error_cnt = 0, samples_checked = 0;
    // mode, first opcode, second opcode (00 for none), lock expected
    logic [32:0] rows [8] = '{{16'h0080, 8'h71, 8'hD0, 1'h0}, {16'h0001, 8'h71, 8'hD0, 1'h1},
        {16'h0001, 8'h21, 8'hD0, 1'h1}, {16'h0001, 8'h20, 8'hD0, 1'h0},
        {16'h0080, 8'hD0, 8'h00, 1'h1}, {16'h0080, 8'hB0, 8'h00, 1'h0},
        {16'h0001, 8'hB3, 8'h00, 1'h0}, {16'h0000, 8'h20, 8'hD0, 1'h0}};
    always #5 core_clk = ~core_clk;
    // short operation counts keep the run brief
    fca_sequencer #(.OP_CYCLES(40), .SUS_CYCLES(8)) fca_sequencer_inst (.*);
    task chk(input string n, input logic [15:0] e, input logic [15:0] g);
        samples_checked++;
        if (g !== e) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask
    task wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge core_clk);
        regAddr <= a;
        regWdata <= d;
        regWr <= 1'h1;
        @(posedge core_clk);
        regWr <= 1'h0;
    endtask
    task cmd(input logic [7:0] b);
        wr(FCA_ADDR_CMD, {8'h00, b});
    endtask
    task rd(input logic [7:0] a);
        @(posedge core_clk);
        regAddr <= a;
        regRd <= 1'h1;
        @(posedge core_clk);
        regRd <= 1'h0;
        #1 st = regRdata;
    endtask
    task wait_rdy;
        repeat (3) @(posedge core_clk);
        for (int i = 0; i < 400 && sequencerReadyFlag !== 1'h1; i++) @(posedge core_clk);
        #1;
    endtask
    task rst;
        nrst <= 1'h0;
        repeat (2) @(posedge core_clk);
        nrst <= 1'h1;
    endtask
    task stop_test;
        if (error_cnt == 0 && samples_checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        rst;
        chk("mode", 16'h0000, sequencerModeSelect);
        chk("flags", 16'h0002, {14'h0, flags});
        foreach (rows[i]) begin
            rst;
            wr(FCA_ADDR_MODE, rows[i][32:17]);
            cmd(rows[i][16:9]);
            if (rows[i][8:1] != 8'h00) cmd(rows[i][8:1]);
            wait_rdy;
            chk("row flags", {15'h0001, rows[i][0]}, {14'h0, flags});
        end
        // erase is suspended, then a program aimed at that same block must lock
        rst;
        wr(FCA_ADDR_MODE, FCA_MODE_DATA);
        cmd(FCA_OP_ERASE);
        cmd(FCA_OP_FINAL);
        st = 16'h0000;
        for (int i = 0; i < 40 && st[FCA_ST_SUSPEND_READY_FLAG] !== 1'h1; i++) rd(FCA_ADDR_STATUS);
        chk("busy status", 16'h0800, st & 16'h8B00);
        cmd(FCA_OP_SUSPEND);
        wait_rdy;
        rd(FCA_ADDR_STATUS);
        chk("suspended status", 16'h8200, st & 16'h8B00);
        cmd(FCA_OP_PROG);
        wr(FCA_ADDR_CMD, 16'h0002);
        wr(FCA_ADDR_CMD, 16'h1234);
        wr(FCA_ADDR_CMD, 16'h5678);
        cmd(FCA_OP_FINAL);
        wait_rdy;
        chk("same block lock", 16'h0001, {15'h0, commandLockFlag});
        cmd(FCA_OP_CLEAR);
        wait_rdy;
        chk("cleared lock", 16'h0000, {15'h0, commandLockFlag});
        wr(FCA_ADDR_TARGET, 16'h0040);
        cmd(FCA_OP_PROG);
        wr(FCA_ADDR_CMD, 16'h0002);
        wr(FCA_ADDR_CMD, 16'h1234);
        wr(FCA_ADDR_CMD, 16'h5678);
        cmd(FCA_OP_FINAL);
        rd(FCA_ADDR_STATUS);
        chk("prog in suspend", 16'h0200, st & 16'h8B00);
        wait_rdy;
        chk("other block", 16'h0002, {14'h0, flags});
        cmd(FCA_OP_STOP);
        wait_rdy;
        wr(FCA_ADDR_CLKNOTE, 16'h0032);
        cmd(FCA_OP_ERASE);
        cmd(FCA_OP_FINAL);
        arrayEraseFail <= 1'h1;
        rd(FCA_ADDR_ACCESS);
        rd(FCA_ADDR_ACCESS);
        chk("error lock", 16'h0001, st);
        chk("busy lock", 16'h0001, {14'h0, flags});
        arrayEraseFail <= 1'h0;
        cmd(FCA_OP_STOP);
        wait_rdy;
        chk("stop frees", 16'h0002, {14'h0, flags});
        wr(FCA_ADDR_MODE, FCA_MODE_READ);
        rd(FCA_ADDR_MODE);
        chk("read mode", 16'h0000, st);
        stop_test;
    end
    initial begin
        #200000;
        error_cnt++;
        stop_test;
    end
endmodule // tb
`default_nettype wire
